// ==== design/rtc_serial_slave_supervisor.sv ====
// two-wire serial slave front end with watchdog and reset supervisor
// assumes open-drain bus resolved outside; mem_rdata follows mem_addr combinationally
//
// Functional notes
// - watchdog field 11 off, 10 250ms, 01 750ms, 00 1.75s
// - each start reloads watchdog to full selected period
// - watchdog expiry asserts reset output for 250ms
// - start during reset timeout changes neither watchdog nor reset
// - watchdog inactive while running from battery
// - power-up holds reset until supply good for 250ms
// - memory array refused while power-on reset asserted
// - low supply asserts reset, released 250ms after recovery
// - low-voltage reset aborts nonvolatile write only on battery
// - low-voltage reset aborts bus transaction and ignores commands
// - on battery reset stays asserted until back on main supply
// - bus traffic ignored until start: data falls with clock high
// - stop, data rising with clock high, ends every transaction
// - acknowledge matching slave address and each written byte
// - no acknowledge for unmatched slave address byte
// - read sends 8 bits, samples ack, continues or stops
// - 1010 array, 1101 control space, select bits 111
// - slave address bit 0: one read, zero write
// - two-byte word address; counter cleared to zero at reset
// - during nonvolatile write ignore bus, data line released
`timescale 1ns/1ps
module rtc_serial_slave_supervisor
    import rtc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // supply monitors and supervisor
    input wire logic vdd_ok_in,
    input wire logic on_batt_in,
    input wire logic watchdog_period_hi,
    input wire logic watchdog_period_lo,
    output logic reset_out_n,
    // memory and control space port
    input wire logic nv_busy,
    input wire logic [7:0] mem_rdata,
    output logic [15:0] mem_addr,
    output logic mem_sel_ccr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic nv_abort
);

    sup_if sif ();

    ////////////////////////////////////////////////////////////////////////
    // pins pass two flops; only the second stage is read
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic scl_d_r;
    logic sda_d_r;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            meta_r <= 4'h7;
            sync_r <= 4'h7;
        end
        else
        begin
            meta_r <= {on_batt_in, vdd_ok_in, sda_in, scl_in};
            sync_r <= meta_r;
        end
    end

    wire scl_s = sync_r[0];
    wire sda_s = sync_r[1];

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    wire start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
    wire stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
    wire scl_rise = scl_s && !scl_d_r;
    wire scl_fall = !scl_s && scl_d_r;

    assign sif.start_det = start_det;
    assign sif.vdd_ok = sync_r[2];
    assign sif.on_batt = sync_r[3];
    assign sif.wd_period = {watchdog_period_hi, watchdog_period_lo};

    rtc_supervisor #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_sup (
        .clk(clk),
        .srst(srst),
        .sif(sif.sup)
    );

    ////////////////////////////////////////////////////////////////////////
    bus_state_t st_r;
    bus_state_t st_nxt;
    byte_kind_t kind_r;
    byte_kind_t kind_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic [7:0] wa_hi_r;
    logic [7:0] wa_hi_nxt;
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;
    logic drv_r;
    logic drv_nxt;
    logic rw_r;
    logic rw_nxt;
    logic ccr_r;
    logic ccr_nxt;
    logic mack_r;
    logic mack_nxt;
    logic rd_nxt;
    logic wr_nxt;
    logic [7:0] wdata_nxt;
    logic load_tx;

    // a write cycle in flight or a low supply locks the bus out entirely
    wire bus_block = sif.lvr_active || nv_busy;
    wire hit_arr = (sh_r[7:4] == DEV_ARRAY);
    wire hit_ccr = (sh_r[7:4] == DEV_CCR);
    wire sel_ok = (sh_r[3:1] == DEV_SELECT);
    wire addr_hit = sel_ok && (hit_ccr || (hit_arr && !sif.por_active));
    wire byte_end = scl_fall && (cnt_r == BITS_PER_BYTE);
    wire tx_last = (cnt_r == BITS_PER_BYTE);

    always_comb
    begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        tx_nxt = tx_r;
        wa_hi_nxt = wa_hi_r;
        addr_nxt = addr_r;
        drv_nxt = drv_r;
        rw_nxt = rw_r;
        ccr_nxt = ccr_r;
        mack_nxt = mack_r;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
        wdata_nxt = mem_wdata;
        load_tx = 1'b0;
        if (bus_block)
        begin
            st_nxt = ST_IDLE;
            drv_nxt = 1'b0;
        end
        else if (start_det)
        begin
            st_nxt = ST_RX;
            kind_nxt = K_SLAVE;
            cnt_nxt = 4'h0;
            drv_nxt = 1'b0;
        end
        else if (stop_det)
        begin
            st_nxt = ST_IDLE;
            drv_nxt = 1'b0;
        end
        else
        begin
            unique case (st_r)
                ST_IDLE: drv_nxt = 1'b0;
                ST_RX:
                begin
                    if (scl_rise)
                    begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    else if (byte_end)
                    begin
                        cnt_nxt = 4'h0;
                        st_nxt = ST_ACK;
                        drv_nxt = 1'b1;
                        unique case (kind_r)
                            K_SLAVE:
                            begin
                                if (!addr_hit)
                                begin
                                    st_nxt = ST_IDLE;
                                    drv_nxt = 1'b0;
                                end
                                rw_nxt = sh_r[0];
                                ccr_nxt = hit_ccr;
                                kind_nxt = K_AHI;
                            end
                            K_AHI:
                            begin
                                wa_hi_nxt = sh_r;
                                kind_nxt = K_ALO;
                            end
                            K_ALO:
                            begin
                                addr_nxt = {wa_hi_r, sh_r};
                                kind_nxt = K_DATA;
                            end
                            K_DATA:
                            begin
                                wr_nxt = 1'b1;
                                wdata_nxt = sh_r;
                                addr_nxt = addr_r + 16'h0001;
                            end
                        endcase
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        drv_nxt = 1'b0;
                        st_nxt = ST_RX;
                        load_tx = rw_r;
                    end
                end
                ST_TX:
                begin
                    if (scl_fall && tx_last)
                    begin
                        drv_nxt = 1'b0;
                        st_nxt = ST_RACK;
                    end
                    else if (scl_fall)
                    begin
                        drv_nxt = !tx_r[7];
                        tx_nxt = {tx_r[6:0], 1'b0};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise) mack_nxt = !sda_s;
                    else if (scl_fall && mack_r) load_tx = 1'b1;
                    else if (scl_fall) st_nxt = ST_IDLE;
                end
            endcase
            // byte fetch shared by first read byte and each acknowledged one
            if (load_tx)
            begin
                st_nxt = ST_TX;
                rd_nxt = 1'b1;
                drv_nxt = !mem_rdata[7];
                tx_nxt = {mem_rdata[6:0], 1'b0};
                cnt_nxt = 4'h1;
                addr_nxt = addr_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_r <= ST_IDLE;
            kind_r <= K_SLAVE;
            cnt_r <= 4'h0;
            drv_r <= 1'b0;
            addr_r <= WORD_ADDR_RST;
        end
        else
        begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            cnt_r <= cnt_nxt;
            drv_r <= drv_nxt;
            addr_r <= addr_nxt;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            wa_hi_r <= 8'h00;
            rw_r <= 1'b0;
            ccr_r <= 1'b0;
            mack_r <= 1'b0;
        end
        else
        begin
            sh_r <= sh_nxt;
            tx_r <= tx_nxt;
            wa_hi_r <= wa_hi_nxt;
            rw_r <= rw_nxt;
            ccr_r <= ccr_nxt;
            mack_r <= mack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory address lags the counter a cycle so a strobe sees the old word
    logic [15:0] mem_addr_r;
    logic rd_r;
    logic wr_r;
    logic [7:0] wdata_r;
    logic sda_out_r;
    logic abort_r;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mem_addr_r <= WORD_ADDR_RST;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            wdata_r <= 8'h00;
            sda_out_r <= 1'b0;
            abort_r <= 1'b0;
        end
        else
        begin
            mem_addr_r <= addr_r;
            rd_r <= rd_nxt;
            wr_r <= wr_nxt;
            wdata_r <= wdata_nxt;
            sda_out_r <= 1'b0;
            abort_r <= sif.lvr_active && sif.on_batt && nv_busy;
        end
    end

    assign sda_out = sda_out_r;
    assign sda_oe = drv_r;
    assign reset_out_n = sif.reset_out_n;
    assign mem_addr = mem_addr_r;
    assign mem_sel_ccr = ccr_r;
    assign mem_rd = rd_r;
    assign mem_wr = wr_r;
    assign mem_wdata = wdata_r;
    assign nv_abort = abort_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    wire quiet = !bus_block && !start_det && !stop_det;
    wire slave_end = (st_r == ST_RX) && (kind_r == K_SLAVE) && byte_end && quiet;

    busy_release_a: assert property (nv_busy |=> !sda_oe && st_r == ST_IDLE)
        else $error("bus driven during write cycle");
    lvr_abort_a: assert property (sif.lvr_active |=> st_r == ST_IDLE)
        else $error("transaction survived low voltage");
    stop_idle_a: assert property (stop_det && !bus_block && !start_det |=>
        st_r == ST_IDLE && !sda_oe) else $error("stop did not end transfer");
    idle_quiet_a: assert property ((st_r == ST_IDLE) && !start_det |=>
        st_r == ST_IDLE && !sda_oe) else $error("idle slave reacted");
    addr_ack_a: assert property (slave_end && addr_hit |=>
        sda_oe && st_r == ST_ACK) else $error("matching address not acked");
    addr_nack_a: assert property (slave_end && !addr_hit |=>
        !sda_oe ##1 !sda_oe) else $error("unmatched address acked");
    por_refuse_a: assert property (slave_end && sif.por_active && hit_arr |=>
        st_r == ST_IDLE) else $error("array reached during power-on reset");
    rw_dir_a: assert property (slave_end && addr_hit |=>
        rw_r == $past(sh_r[0])) else $error("direction bit lost");
    tx_release_a: assert property ((st_r == ST_TX) && scl_fall && tx_last && quiet |=>
        st_r == ST_RACK && !sda_oe) else $error("line held after 8 bits");
    nack_end_a: assert property ((st_r == ST_RACK) && scl_fall && !mack_r && quiet |=>
        st_r == ST_IDLE) else $error("read went on without ack");
    wr_addr_a: assert property (mem_wr |-> addr_r == mem_addr + 16'h0001)
        else $error("word address not advanced");
    abort_gate_a: assert property (nv_abort |-> $past(sif.on_batt))
        else $error("write aborted off battery");

    start_c: cover property (start_det && !bus_block);
    write_c: cover property (mem_wr);
    seq_read_c: cover property (mem_rd ##[1:400] mem_rd);

endmodule // rtc_serial_slave_supervisor

// ==== design/rtc_pkg.sv ====
// constants, state types and timing counts for the serial slave and supervisor
// assumes a 40 MHz system clock; long counts run on a 1 ms internal tick
package rtc_pkg;

    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;

    localparam int MS_W = 11;
    localparam int RST_TMO_MS = 250;
    localparam int WD_MS_SHORT = 250;
    localparam int WD_MS_MID = 750;
    localparam int WD_MS_LONG = 1750;
    localparam logic [MS_W-1:0] RST_TMO_CNT = MS_W'(RST_TMO_MS);
    localparam logic [MS_W-1:0] WD_CNT_SHORT = MS_W'(WD_MS_SHORT);
    localparam logic [MS_W-1:0] WD_CNT_MID = MS_W'(WD_MS_MID);
    localparam logic [MS_W-1:0] WD_CNT_LONG = MS_W'(WD_MS_LONG);

    localparam logic [1:0] WD_SEL_OFF = 2'h3;
    localparam logic [1:0] WD_SEL_SHORT = 2'h2;
    localparam logic [1:0] WD_SEL_MID = 2'h1;

    localparam logic [3:0] DEV_ARRAY = 4'ha;
    localparam logic [3:0] DEV_CCR = 4'hd;
    localparam logic [2:0] DEV_SELECT = 3'h7;
    localparam logic [15:0] WORD_ADDR_RST = 16'h0000;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {S_POR, S_RUN, S_LOW, S_TMO, S_BATT} sup_state_t;
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK} bus_state_t;
    typedef enum logic [1:0] {K_SLAVE, K_AHI, K_ALO, K_DATA} byte_kind_t;

endpackage

// ==== design/sup_if.sv ====
// link between the serial slave and the supervisor
// assumes all members are on the system clock domain
`timescale 1ns/1ps
interface sup_if;
    logic start_det;
    logic vdd_ok;
    logic on_batt;
    logic [1:0] wd_period;
    logic por_active;
    logic lvr_active;
    logic reset_out_n;

    modport bus (
        output start_det, vdd_ok, on_batt, wd_period,
        input por_active, lvr_active, reset_out_n
    );
    modport sup (
        input start_det, vdd_ok, on_batt, wd_period,
        output por_active, lvr_active, reset_out_n
    );
endinterface // sup_if

// ==== design/rtc_supervisor.sv ====
// watchdog and power-on / low-voltage reset sequencing
// assumes vdd_ok and on_batt arrive already synchronised
`timescale 1ns/1ps
module rtc_supervisor
    import rtc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
)
(
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // link to the serial slave
    sup_if.sup sif
);

    logic [31:0] div_r;
    logic [MS_W-1:0] rst_ms_r;
    logic [MS_W-1:0] wd_ms_r;
    sup_state_t st_r;
    sup_state_t st_nxt;
    logic reset_n_r;
    logic por_r;
    logic lvr_r;

    ////////////////////////////////////////////////////////////////////////
    wire tick = (div_r == 32'(TICK_CYCLES - 1));
    wire wd_on = (sif.wd_period != WD_SEL_OFF) && !sif.on_batt;
    wire [MS_W-1:0] wd_load = (sif.wd_period == WD_SEL_SHORT) ? WD_CNT_SHORT :
                              (sif.wd_period == WD_SEL_MID) ? WD_CNT_MID :
                              WD_CNT_LONG;
    wire rst_done = tick && (rst_ms_r >= RST_TMO_CNT - MS_W'(1));
    wire wd_expire = (st_r == S_RUN) && wd_on && tick && (wd_ms_r <= MS_W'(1));
    sup_state_t drop_st;
    assign drop_st = sif.on_batt ? S_BATT : S_LOW;

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            S_POR: if (sif.vdd_ok && rst_done) st_nxt = S_RUN;
            S_RUN:
            begin
                if (!sif.vdd_ok) st_nxt = sup_state_t'(drop_st);
                else if (wd_expire) st_nxt = S_TMO;
            end
            S_LOW:
            begin
                if (sif.on_batt) st_nxt = S_BATT;
                else if (sif.vdd_ok) st_nxt = S_TMO;
            end
            S_TMO:
            begin
                if (!sif.vdd_ok) st_nxt = sup_state_t'(drop_st);
                else if (rst_done) st_nxt = S_RUN;
            end
            S_BATT: if (!sif.on_batt) st_nxt = sif.vdd_ok ? S_TMO : S_LOW;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst) div_r <= 32'h0;
        else div_r <= tick ? 32'h0 : div_r + 32'h1;
    end

    // supply must stay good for the whole count; any dip restarts it
    always_ff @(posedge clk)
    begin
        if (srst || st_nxt != st_r || !sif.vdd_ok) rst_ms_r <= '0;
        else if (tick) rst_ms_r <= rst_ms_r + MS_W'(1);
    end

    // start during a timeout is swallowed: the counter is reloaded anyway
    always_ff @(posedge clk)
    begin
        if (srst || st_r != S_RUN || !wd_on || sif.start_det) wd_ms_r <= wd_load;
        else if (tick && wd_ms_r != '0) wd_ms_r <= wd_ms_r - MS_W'(1);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_r <= S_POR;
            reset_n_r <= 1'b0;
            por_r <= 1'b1;
            lvr_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            reset_n_r <= (st_nxt == S_RUN);
            por_r <= (st_nxt == S_POR);
            lvr_r <= (st_nxt == S_LOW) || (st_nxt == S_BATT);
        end
    end

    assign sif.reset_out_n = reset_n_r;
    assign sif.por_active = por_r;
    assign sif.lvr_active = lvr_r;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    wd_reload_a: assert property ((st_r == S_RUN) && wd_on && sif.start_det |=>
        wd_ms_r == $past(wd_load)) else $error("start did not reload watchdog");
    wd_expire_a: assert property (wd_expire && sif.vdd_ok |=>
        !sif.reset_out_n && st_r == S_TMO) else $error("watchdog expiry lost");
    tmo_start_a: assert property ((st_r == S_TMO) && sif.start_det && !rst_done |=>
        !sif.reset_out_n) else $error("start ended reset timeout");
    batt_wd_a: assert property (sif.on_batt |-> !wd_expire)
        else $error("watchdog active on battery");
    low_hold_a: assert property (!sif.vdd_ok |=> !sif.reset_out_n)
        else $error("reset released with supply low");
    batt_hold_a: assert property ((st_r == S_BATT) && sif.on_batt |=>
        !sif.reset_out_n) else $error("reset released on battery");
    wd_short_a: assert property ((sif.wd_period == WD_SEL_SHORT) |->
        wd_load == 11'h0fa) else $error("watchdog short period wrong");

    wd_fire_c: cover property (wd_expire);
    por_done_c: cover property ((st_r == S_POR) ##1 (st_r == S_RUN));

endmodule // rtc_supervisor

// ==== sim/bus_master.sv ====
// two-wire bus master model: start, stop, byte write, byte read
// assumes a pull-up on the data line; bus clock idles high between frames
`timescale 1ns/1ps
module bus_master (
    // bus lines: clock push-pull, data open drain
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    logic s;
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // 200 ns bit: device answer lands three clocks after a fall, ahead of the rise
    task automatic bit_cyc(input logic b, output logic smp);
        #50 sda_pull = !b;
        #50 scl = 1'b1;
        #75 smp = sda_line;
        #25 scl = 1'b0;
    endtask
    task automatic start();
        #50 sda_pull = 1'b0;
        #100 scl = 1'b1;
        #100 sda_pull = 1'b1;
        #100 scl = 1'b0;
    endtask
    task automatic stop();
        #50 sda_pull = 1'b1;
        #100 scl = 1'b1;
        #100 sda_pull = 1'b0;
        #100;
    endtask
    task automatic wr(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_cyc(b[i], s);
        bit_cyc(1'b1, s);
        ack = !s;
    endtask
    task automatic rd(input logic ack, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_cyc(1'b1, d[i]);
        bit_cyc(!ack, s);
    endtask
endmodule // bus_master

// ==== sim/rtc_serial_slave_supervisor_tb.sv ====
// bench: word pointer and write queue model against the serial slave
// assumes bus_master as far side; tick of 4 clocks so 250 ms is 1000 clocks
`timescale 1ns/1ps
module rtc_serial_slave_supervisor_tb
    import rtc_pkg::*;
;
    localparam int TK = 4;
    localparam int T250 = RST_TMO_MS * TK;
    logic clk = 1'b0, srst = 1'b1, vdd_ok_in = 1'b1, on_batt_in = 1'b0, nv_busy = 1'b0;
    logic [1:0] wd = 2'h3;
    logic scl, pull, sda_line, sda_out, sda_oe, reset_out_n, mem_sel_ccr, mem_rd, mem_wr;
    logic nv_abort, ak;
    logic [7:0] mem_rdata, mem_wdata, d8, b;
    logic [15:0] mem_addr, ptr, a, v;
    logic [31:0] rs = 32'h28;
    logic [23:0] wq[$];
    int n_fail = 0, n_compared = 0, p;
    always #12.5 clk = ~clk;
    assign sda_line = !(pull || sda_oe);
    assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c;
    bus_master m (.scl(scl), .sda_pull(pull), .sda_line(sda_line));
    rtc_serial_slave_supervisor #(.TICK_CYCLES(TK)) u_dut (.clk(clk), .srst(srst),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .vdd_ok_in(vdd_ok_in), .on_batt_in(on_batt_in), .watchdog_period_hi(wd[1]),
        .watchdog_period_lo(wd[0]), .reset_out_n(reset_out_n), .nv_busy(nv_busy),
        .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_sel_ccr(mem_sel_ccr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .nv_abort(nv_abort));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rdv(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h3c;
    endfunction
    function logic [15:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[15:0];
    endfunction
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask
    task automatic chk_val(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic sb_try(input logic [7:0] sb, input logic e);
        m.start();
        m.wr(sb, ak);
        chk_bit("ack", e, ak);
        m.stop();
    endtask
    task automatic set_ptr(input logic [15:0] x);
        m.start();
        m.wr(8'hae, ak);
        chk_bit("ack", 1'b1, ak);
        m.wr(x[15:8], ak);
        chk_bit("ack", 1'b1, ak);
        m.wr(x[7:0], ak);
        chk_bit("ack", 1'b1, ak);
        ptr = x;
    endtask
    task automatic rd_chk(input logic ack);
        m.rd(ack, d8);
        chk_val("rd", 24'(rdv(ptr)), 24'(d8));
        ptr++;
    endtask
    task automatic end_sim();
        $display("fails %0d compares %0d", n_fail, n_compared);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk)
    begin
        if (mem_wr)
            chk_val("wr", wq.size() > 0 ? wq.pop_front() : 24'hx, {mem_addr, mem_wdata});
        if (mem_rd)
            chk_val("rd_addr", {8'h00, ptr}, {7'h00, mem_sel_ccr, mem_addr});
    end
    initial
    begin
        #1500000;
        n_fail++;
        end_sim();
    end
    initial
    begin
        step(12);
        srst = 1'b0;
        step(20);
        sb_try(8'hae, 1'b0);
        sb_try(8'hde, 1'b1);
        chk_bit("ccr", 1'b1, mem_sel_ccr);
        step(600);
        chk_bit("rst_n", 1'b0, reset_out_n);
        step(400);
        chk_bit("rst_n", 1'b1, reset_out_n);
        repeat (6)
        begin
            v = rnd();
            b = {v[7:1], 1'b0};
            sb_try(b, b[7:1] == 7'h57 || b[7:1] == 7'h6f);
        end
        sb_try(8'ha6, 1'b0);
        set_ptr(rnd());
        repeat (2)
        begin
            v = rnd();
            wq.push_back({ptr, v[7:0]});
            m.wr(v[7:0], ak);
            chk_bit("ack", 1'b1, ak);
            ptr++;
        end
        m.stop();
        set_ptr(rnd());
        m.start();
        m.wr(8'haf, ak);
        chk_bit("ack", 1'b1, ak);
        rd_chk(1'b1);
        rd_chk(1'b0);
        m.stop();
        m.start();
        m.wr(8'haf, ak);
        chk_bit("ack", 1'b1, ak);
        rd_chk(1'b0);
        m.stop();
        step(1);
        nv_busy = 1'b1;
        sb_try(8'haf, 1'b0);
        step(1);
        nv_busy = 1'b0;
        wd = 2'h2;
        sb_try(8'hde, 1'b1);
        step(T250 - 150);
        chk_bit("rst_n", 1'b1, reset_out_n);
        sb_try(8'hde, 1'b1);
        step(T250 - 150);
        chk_bit("rst_n", 1'b1, reset_out_n);
        step(250);
        chk_bit("rst_n", 1'b0, reset_out_n);
        m.start();
        m.stop();
        step(T250 - 250);
        chk_bit("rst_n", 1'b0, reset_out_n);
        step(200);
        chk_bit("rst_n", 1'b1, reset_out_n);
        for (int i = 0; i < 2; i++)
        begin
            step(1);
            wd = 2'(1 - i);
            p = (i == 1 ? WD_MS_LONG : WD_MS_MID) * TK;
            sb_try(8'hde, 1'b1);
            step(p - 100);
            chk_bit("rst_n", 1'b1, reset_out_n);
            step(200);
            chk_bit("rst_n", 1'b0, reset_out_n);
            step(T250 + 50);
        end
        wd = 2'h3;
        step(2000);
        chk_bit("rst_n", 1'b1, reset_out_n);
        vdd_ok_in = 1'b0;
        nv_busy = 1'b1;
        step(10);
        chk_bit("rst_n", 1'b0, reset_out_n);
        chk_bit("abort", 1'b0, nv_abort);
        nv_busy = 1'b0;
        sb_try(8'hde, 1'b0);
        step(1);
        vdd_ok_in = 1'b1;
        step(T250 - 100);
        chk_bit("rst_n", 1'b0, reset_out_n);
        step(200);
        chk_bit("rst_n", 1'b1, reset_out_n);
        on_batt_in = 1'b1;
        wd = 2'h2;
        step(T250 + 200);
        chk_bit("rst_n", 1'b1, reset_out_n);
        wd = 2'h3;
        nv_busy = 1'b1;
        vdd_ok_in = 1'b0;
        step(10);
        chk_bit("abort", 1'b1, nv_abort);
        vdd_ok_in = 1'b1;
        step(T250 + 200);
        chk_bit("rst_n", 1'b0, reset_out_n);
        on_batt_in = 1'b0;
        nv_busy = 1'b0;
        step(T250 + 100);
        chk_bit("rst_n", 1'b1, reset_out_n);
        chk_bit("sda_out", 1'b0, sda_out);
        end_sim();
    end
endmodule // rtc_serial_slave_supervisor_tb
